// File: adc_port_params.svh
// Timing counts, pin positions and reset values of the result port
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

`define SYS_CLK_MHZ 100
`define CONV_TIME_NS 650
`define CONV_CYCLES ((`CONV_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SCLK_QUARTER_NS 20
`define SCLK_QUARTER_CYCLES ((`SCLK_QUARTER_NS * `SYS_CLK_MHZ + 999) / 1000)
`define ERR_PULSE_NS 100
`define ERR_PULSE_CYCLES ((`ERR_PULSE_NS * `SYS_CLK_MHZ + 999) / 1000)

`define RESULT_BITS 5'h10
`define CODING_FLIP 16'h8000
`define PIN_SDATA 8
`define PIN_SCLK 9
`define PIN_FRAME 10
`define PIN_ERROR 11
`define SYNC_INIT 9'h1C0
`define OE_ALL_OFF 16'hFFFF

`endif

// File: adc_port_pkg.sv
// Types shared by the result port modules
package adc_port_pkg;

  typedef struct packed {
    logic portSerial;
    logic clockExternal;
    logic clockInvert;
    logic framePolarity;
    logic codingTwos;
  } port_config_type;

  typedef struct packed {
    logic conversionStartN;
    logic converterSelectN;
    logic readEnableN;
    logic shiftClock;
    port_config_type cfg;
  } pin_sample_type;

  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } serial_state_type;

endpackage

// File: sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Q;
  logic [WIDTH-1:0] stage2Q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1Q <= INIT;
      stage2Q <= INIT;
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
    end
  end

  assign syncOut = stage2Q;
endmodule

// File: word_buffer.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  logic [WIDTH-1:0] entryQ [2];
  logic [WIDTH-1:0] entryD [2];
  logic headQ;
  logic headD;
  logic [1:0] countQ;
  logic [1:0] countD;
  logic push;
  logic pop;

  assign inReady = (countQ != 2'h2);
  assign outValid = (countQ != 2'h0);
  assign outData = entryQ[headQ];

  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    entryD = entryQ;
    headD = headQ;
    countD = countQ;
    if (push) begin
      entryD[headQ ^ countQ[0]] = inData;
    end
    if (pop) begin
      headD = ~headQ;
    end
    if (push && !pop) begin
      countD = countQ + 2'h1;
    end else if (pop && !push) begin
      countD = countQ - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      entryQ[0] <= '0;
      entryQ[1] <= '0;
      headQ <= 1'b0;
      countQ <= 2'h0;
    end else begin
      entryQ <= entryD;
      headQ <= headD;
      countQ <= countD;
    end
  end
endmodule

// File: adc_result_output_port.sv
// Result output port: conversion timing, parallel and serial delivery
// Functional notes
// [RULE1] Serial mode: bit-8 pin carries serial result, timed by shift clock.
// [RULE2] Parallel mode: pins 8 to 11 carry result bits 8 to 11.
// [RULE3] Result held in shift register, shifted out MSB first.
// [RULE4] Coding select picks offset binary or two's complement output.
// [RULE5] Master mode: serial data stable at both shift clock edges.
// [RULE6] Slave, invert low: data changes on rising edge.
// [RULE7] Slave, invert high: data changes on falling edge.
// [RULE8] Clock pin driven by device in master, driven by host in slave.
// [RULE9] Serial mode: bit-10 pin is frame marker, master clock only.
// [RULE10] Polarity low: frame marker high while serial data valid.
// [RULE11] Polarity high: frame marker low while serial data valid.
// [RULE12] Slave serial mode: bit-11 pin is incomplete-read error flag.
// [RULE13] Slave read unfinished at next conversion end: drop data, pulse error.
// [RULE14] Serial mode: parallel bits 12 to 15 in high impedance.
// [RULE15] Busy rises at conversion start, falls once result is latched.
// [RULE16] Host may use busy falling edge as data-ready strobe.
// [RULE17] Clock select low: device makes clock; high: host clock, chip-gated.
// [RULE18] Drivers enabled only while select and read enable both low.
// [RULE19] Falling edge on conversion start begins a conversion.
// [RULE20] Reset high resets logic and aborts a running conversion.
// [RULE21] Each serial read moves exactly sixteen bits, one per clock period.
`timescale 1ns/1ps
`include "adc_port_params.svh"
module adc_result_output_port
  import adc_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Conversion control and raw result from the converter core
  input wire logic conversionStartN,
  input wire logic [15:0] sarResult,
  // Host read control
  input wire logic converterSelectN,
  input wire logic readEnableN,
  // Port configuration levels
  input wire logic portFormatSelect,
  input wire logic clockSourceSelect,
  input wire logic shiftClockInvert,
  input wire logic frameMarkerPolarity,
  input wire logic outputCodingSelect,
  // Shift clock pin input side
  input wire logic shiftClockIn,
  // Data pins and status
  output logic [15:0] dataOut,
  output logic [15:0] dataOeN,
  output logic busy
);
  localparam logic [7:0] CONV_COUNT = 8'(`CONV_CYCLES);
  localparam logic [3:0] QUARTER_LAST = 4'(`SCLK_QUARTER_CYCLES - 1);
  localparam logic [4:0] ERR_COUNT = 5'(`ERR_PULSE_CYCLES);

  pin_sample_type pinsRaw;
  pin_sample_type pinsS;
  port_config_type cfg;
  logic outEnable;
  logic master;
  logic slave;

  // Conversion group
  logic startPrevQ, startPrevD;
  logic convActiveQ, convActiveD;
  logic [7:0] convCountQ, convCountD;
  logic pendingQ, pendingD;
  logic [15:0] pendWordQ, pendWordD;
  logic busyQ, busyD;
  logic pushFire;

  // Buffer wires
  logic bufInReady;
  logic bufOutValid;
  logic [15:0] bufOutData;
  logic popReady;
  logic popFire;

  // Delivery group
  serial_state_type stateQ, stateD;
  logic [15:0] shiftQ, shiftD;
  logic [4:0] bitsLeftQ, bitsLeftD;
  logic [1:0] phaseQ, phaseD;
  logic [3:0] divQ, divD;
  logic sclkPrevQ, sclkPrevD;
  logic [4:0] errCountQ, errCountD;
  logic [15:0] resultQ, resultD;
  logic [15:0] dataOutQ, dataOutD;
  logic [15:0] dataOeNQ, dataOeND;
  logic sclkLevel;
  logic updateEdge;
  logic readStarted;

  assign pinsRaw = '{conversionStartN: conversionStartN,
                     converterSelectN: converterSelectN,
                     readEnableN: readEnableN,
                     shiftClock: shiftClockIn,
                     cfg: '{portSerial: portFormatSelect,
                            clockExternal: clockSourceSelect,
                            clockInvert: shiftClockInvert,
                            framePolarity: frameMarkerPolarity,
                            codingTwos: outputCodingSelect}};

  // Reset values equal the idle pin levels: no false edge
  sync2 #(
    .WIDTH($bits(pin_sample_type)),
    .INIT(`SYNC_INIT)
  ) pinSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn(pinsRaw),
    .syncOut(pinsS)
  );

  word_buffer #(
    .WIDTH(16)
  ) resultBuffer (
    .sys_clk(sys_clk),
    .reset(reset),
    .inValid(pendingQ),
    .inData(pendWordQ),
    .inReady(bufInReady),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outReady(popReady)
  );

  assign cfg = pinsS.cfg;
  assign outEnable = !pinsS.converterSelectN && !pinsS.readEnableN; // RULE18
  assign master = cfg.portSerial && !cfg.clockExternal; // RULE17
  assign slave = cfg.portSerial && cfg.clockExternal; // RULE17
  // A result waits here while the buffer is full
  assign pushFire = pendingQ && bufInReady;

  // Conversion timing and busy
  always_comb begin
    startPrevD = pinsS.conversionStartN;
    convActiveD = convActiveQ;
    convCountD = convCountQ;
    pendingD = pendingQ;
    pendWordD = pendWordQ;
    if (pushFire) begin
      pendingD = 1'b0;
    end
    if (convActiveQ) begin
      if (convCountQ == 8'h01) begin
        convActiveD = 1'b0;
        pendingD = 1'b1;
        pendWordD = sarResult ^ (cfg.codingTwos ? `CODING_FLIP : 16'h0000); // RULE4
      end else begin
        convCountD = convCountQ - 8'h01;
      end
    end else if (!pendingQ && startPrevQ && !pinsS.conversionStartN) begin
      convActiveD = 1'b1; // RULE19
      convCountD = CONV_COUNT;
    end
    // Busy covers the wait for buffer space as well
    busyD = convActiveD || pendingD; // RULE15
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin // RULE20
      startPrevQ <= 1'b1;
      convActiveQ <= 1'b0;
      convCountQ <= 8'h00;
      pendingQ <= 1'b0;
      pendWordQ <= 16'h0000;
      busyQ <= 1'b0;
    end else begin
      startPrevQ <= startPrevD;
      convActiveQ <= convActiveD;
      convCountQ <= convCountD;
      pendingQ <= pendingD;
      pendWordQ <= pendWordD;
      busyQ <= busyD;
    end
  end

  // Buffer drain: parallel always, slave once the shifter is free, master also needs outEnable
  always_comb begin
    if (!cfg.portSerial) begin
      popReady = 1'b1;
    end else if (master) begin
      popReady = (stateQ == SER_IDLE) && outEnable;
    end else begin
      popReady = (stateQ == SER_IDLE);
    end
    popFire = popReady && bufOutValid;
  end

  assign sclkLevel = pinsS.shiftClock ^ cfg.clockInvert;
  // Host clock is gated by chip select
  assign updateEdge = sclkLevel && !sclkPrevQ &&
                      !pinsS.converterSelectN; // RULE6 RULE7 RULE17
  // A read counts as started after its first update edge
  assign readStarted = (stateQ == SER_SHIFT) && (bitsLeftQ != `RESULT_BITS);

  // Delivery: parallel word, serial shifter, pins
  always_comb begin
    stateD = stateQ;
    shiftD = shiftQ;
    bitsLeftD = bitsLeftQ;
    phaseD = phaseQ;
    divD = divQ;
    sclkPrevD = sclkLevel;
    // Error pulse counts down in clock cycles
    errCountD = (errCountQ != 5'h00) ? errCountQ - 5'h01 : 5'h00;
    resultD = resultQ;
    if (popFire) begin
      if (!cfg.portSerial) begin
        resultD = bufOutData;
      end else begin
        shiftD = bufOutData; // RULE3
        bitsLeftD = `RESULT_BITS;
        stateD = SER_SHIFT;
        phaseD = 2'h0;
        divD = 4'h0;
      end
    end else if (!cfg.portSerial) begin
      stateD = SER_IDLE;
    end else if (stateQ == SER_SHIFT) begin
      // Host half period must exceed the synchroniser delay
      if (slave) begin
        if (pushFire && readStarted) begin
          stateD = SER_IDLE; // RULE13
          errCountD = ERR_COUNT; // RULE13
        end else if (updateEdge) begin
          if (bitsLeftQ == 5'h01) begin
            stateD = SER_IDLE; // RULE21
          end else begin
            shiftD = {shiftQ[14:0], 1'b0}; // RULE3
            bitsLeftD = bitsLeftQ - 5'h01;
          end
        end
      end else if (divQ == QUARTER_LAST) begin
        // Data moves a quarter before the rise and after the fall
        divD = 4'h0;
        phaseD = phaseQ + 2'h1; // RULE5
        if (phaseQ == 2'h3) begin
          if (bitsLeftQ == 5'h01) begin
            stateD = SER_IDLE; // RULE21
          end else begin
            shiftD = {shiftQ[14:0], 1'b0};
            bitsLeftD = bitsLeftQ - 5'h01;
          end
        end
      end else begin
        divD = divQ + 4'h1;
      end
    end

    dataOutD = 16'h0000;
    dataOeND = `OE_ALL_OFF;
    if (!cfg.portSerial) begin
      dataOutD = resultD; // RULE2
      dataOeND = {16{!outEnable}}; // RULE18
    end else begin
      // Pins 0-7 and 12-15 stay undriven
      dataOutD[`PIN_SDATA] = (stateD == SER_SHIFT) && shiftD[15]; // RULE1
      dataOeND[`PIN_SDATA] = !outEnable; // RULE1 RULE14
      if (master) begin
        dataOutD[`PIN_SCLK] = ((stateD == SER_SHIFT) &&
          (phaseD == 2'h1 || phaseD == 2'h2)) ^ cfg.clockInvert; // RULE5
        dataOeND[`PIN_SCLK] = !outEnable; // RULE8
        dataOutD[`PIN_FRAME] =
          (stateD == SER_SHIFT) ^ cfg.framePolarity; // RULE10 RULE11
        dataOeND[`PIN_FRAME] = !outEnable; // RULE9
      end else begin
        dataOutD[`PIN_ERROR] = (errCountD != 5'h00); // RULE12
        dataOeND[`PIN_ERROR] = !outEnable; // RULE12
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stateQ <= SER_IDLE;
      shiftQ <= 16'h0000;
      bitsLeftQ <= 5'h00;
      phaseQ <= 2'h0;
      divQ <= 4'h0;
      sclkPrevQ <= 1'b0;
      errCountQ <= 5'h00;
      resultQ <= 16'h0000;
      dataOutQ <= 16'h0000;
      dataOeNQ <= `OE_ALL_OFF;
    end else begin
      stateQ <= stateD;
      shiftQ <= shiftD;
      bitsLeftQ <= bitsLeftD;
      phaseQ <= phaseD;
      divQ <= divD;
      sclkPrevQ <= sclkPrevD;
      errCountQ <= errCountD;
      resultQ <= resultD;
      dataOutQ <= dataOutD;
      dataOeNQ <= dataOeND;
    end
  end

  assign dataOut = dataOutQ;
  assign dataOeN = dataOeNQ;
  assign busy = busyQ; // RULE16
endmodule

// File: adc_result_output_port_properties.sv
// Port assertions for the result output port
`timescale 1ns/1ps
`include "adc_port_params.svh"
module adc_result_output_port_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Inputs watched
  input wire logic conversionStartN,
  input wire logic converterSelectN,
  input wire logic readEnableN,
  input wire logic portFormatSelect,
  input wire logic frameMarkerPolarity,
  // Outputs watched
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOeN,
  input wire logic busy
);
  logic [15:0] busyCnt_q, busyCnt_d, frameCnt_q, frameCnt_d;
  logic frameOn;
  assign frameOn = !dataOeN[10] && dataOeN[12]
    && (dataOut[10] != frameMarkerPolarity);
  always_comb begin
    busyCnt_d = busy ? busyCnt_q + 16'h0001 : 16'h0000;
    frameCnt_d = frameOn ? frameCnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk) begin
    busyCnt_q <= reset ? 16'h0000 : busyCnt_d;
    frameCnt_q <= reset ? 16'h0000 : frameCnt_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_idle;
    (!busy && conversionStartN && !portFormatSelect)[*4];
  endsequence
  sequence s_held;
    (!conversionStartN)[*6];
  endsequence
  property p_start;
    s_idle ##1 s_held |-> busy;
  endproperty
  a_start: assert property (p_start)
    else $error("start ignored");
  property p_busyLen;
    $fell(busy) |-> busyCnt_q >= `CONV_CYCLES;
  endproperty
  a_busyLen: assert property (p_busyLen)
    else $error("busy too short");
  property p_frameLen;
    $fell(frameOn) |-> frameCnt_q == 16'h0080;
  endproperty
  a_frameLen: assert property (p_frameLen)
    else $error("frame length wrong");
  property p_masterData;
    !dataOeN[9] && dataOeN[12] && $changed(dataOut[8])
      |-> $stable(dataOut[9]) ##1 $stable(dataOut[9]);
  endproperty
  a_masterData: assert property (p_masterData)
    else $error("data moved near clock edge");
  property p_errPulse;
    $rose(dataOut[11]) && dataOeN[15:8] == 8'hF6
      |-> dataOut[11][*8] ##1 dataOut[11][*2] ##1 !dataOut[11];
  endproperty
  a_errPulse: assert property (p_errPulse)
    else $error("error pulse length");
  property p_serialHiZ;
    portFormatSelect[*4] |-> dataOeN[15:12] == 4'hF;
  endproperty
  a_serialHiZ: assert property (p_serialHiZ)
    else $error("high bits driven");
  property p_off;
    (converterSelectN || readEnableN)[*4] |-> dataOeN == 16'hFFFF;
  endproperty
  a_off: assert property (p_off)
    else $error("drivers on while deselected");
  property p_parOn;
    (!portFormatSelect && !converterSelectN && !readEnableN)[*4]
      |-> dataOeN == 16'h0000;
  endproperty
  a_parOn: assert property (p_parOn)
    else $error("parallel drivers off");
  property p_reset;
    disable iff (1'b0) reset |=> !busy && dataOeN == 16'hFFFF;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");
endmodule

// File: host_reader_model.sv
// Host side reader of serial result words
`timescale 1ns/1ps
module host_reader_model (
  // Pins seen by the host
  input wire logic [15:0] dataOut,
  input wire logic shiftClockInvert,
  // Shift clock for slave reads
  output logic hostClock
);
  logic phase = 1'b0;
  // Stands at the inactive level between frames
  assign hostClock = phase ^ shiftClockInvert;
  task automatic read_slave(input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < n; i++) begin
      w = {w[14:0], dataOut[8]};
      #62.5 phase = 1'b1;
      #62.5 phase = 1'b0;
    end
  endtask
  task automatic read_master(output logic [15:0] w);
    w = 16'h0000;
    repeat (16) begin
      wait (dataOut[9] != shiftClockInvert);
      w = {w[14:0], dataOut[8]};
      wait (dataOut[9] == shiftClockInvert);
    end
  endtask
endmodule

// File: adc_result_output_port_tb_top.sv
// Self-checking bench for the result output port
`timescale 1ns/1ps
module adc_result_output_port_tb_top
  import adc_port_pkg::*;
;
  logic sys_clk = 1'b0, reset = 1'b1, conversionStartN = 1'b1;
  logic converterSelectN = 1'b1, readEnableN = 1'b1, busy, hostClock;
  logic shiftClockIn;
  logic [15:0] sarResult = 16'h0000, dataOut, dataOeN, word;
  port_config_type cfg = '0;
  int n_errors = 0, n_tests = 0;
  assign shiftClockIn = dataOeN[9] ? hostClock : dataOut[9];
  always #5 sys_clk = ~sys_clk;
  adc_result_output_port adc_result_output_port_i (
    .sys_clk(sys_clk), .reset(reset), .conversionStartN(conversionStartN),
    .sarResult(sarResult), .converterSelectN(converterSelectN),
    .readEnableN(readEnableN), .portFormatSelect(cfg.portSerial),
    .clockSourceSelect(cfg.clockExternal),
    .shiftClockInvert(cfg.clockInvert),
    .frameMarkerPolarity(cfg.framePolarity),
    .outputCodingSelect(cfg.codingTwos), .shiftClockIn(shiftClockIn),
    .dataOut(dataOut), .dataOeN(dataOeN), .busy(busy));
  host_reader_model host_reader_model_i (.dataOut(dataOut),
    .shiftClockInvert(cfg.clockInvert), .hostClock(hostClock));
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Configuration changes only while drivers are off
  task automatic setup(input port_config_type c);
    converterSelectN = 1'b1;
    readEnableN = 1'b1;
    repeat (5) tick;
    cfg = c;
    repeat (5) tick;
    converterSelectN = 1'b0;
    readEnableN = 1'b0;
    repeat (5) tick;
  endtask
  task automatic convert(input logic [15:0] v);
    int k;
    conversionStartN = 1'b1;
    repeat (4) tick;
    sarResult = v;
    conversionStartN = 1'b0;
    for (k = 0; k < 300 && busy !== 1'b1; k++) tick;
    chk(busy === 1'b1, "busy stuck low");
    for (k = 0; k < 300 && busy !== 1'b0; k++) tick;
    chk(busy === 1'b0, "busy stuck high");
  endtask
  task automatic t_parallel;
    for (int m = 0; m < 2; m++) begin
      setup('{1'b0, 1'b0, 1'b0, 1'b0, m[0]});
      convert(16'h5AC3);
      repeat (3) tick;
      chk(dataOut === (m ? 16'hDAC3 : 16'h5AC3), "parallel word");
      chk(dataOeN === 16'h0000, "parallel drive");
    end
    readEnableN = 1'b1;
    repeat (5) tick;
    chk(dataOeN === 16'hFFFF, "drivers left on");
  endtask
  task automatic t_master;
    for (int p = 0; p < 2; p++) begin
      setup('{1'b1, 1'b0, p[0], p[0], p[0]});
      fork
        convert(16'hB38E);
        host_reader_model_i.read_master(word);
      join
      repeat (10) tick;
      chk(word === (p ? 16'h338E : 16'hB38E), "master word");
      chk(dataOeN === 16'hF8FF, "master drive");
      chk(dataOut[10] === p[0], "frame idle");
    end
  endtask
  task automatic t_slave;
    for (int p = 0; p < 2; p++) begin
      setup('{1'b1, 1'b1, p[0], 1'b0, 1'b0});
      convert(16'h6D29 ^ {16{p[0]}});
      repeat (3) tick;
      chk(dataOeN === 16'hF6FF, "slave drive");
      chk(dataOut[11] === 1'b0, "flag set");
      host_reader_model_i.read_slave(16, word);
      chk(word === (16'h6D29 ^ {16{p[0]}}), "slave word");
    end
  endtask
  task automatic t_error;
    int k;
    convert(16'h1234);
    repeat (3) tick;
    host_reader_model_i.read_slave(4, word);
    convert(16'hFEDC);
    for (k = 0; k < 30 && dataOut[11] !== 1'b1; k++) tick;
    chk(dataOut[11] === 1'b1, "no error pulse");
    repeat (12) tick;
    host_reader_model_i.read_slave(16, word);
    chk(word === 16'hFEDC, "word after error");
  endtask
  task automatic t_reset;
    setup('0);
    conversionStartN = 1'b1;
    repeat (4) tick;
    conversionStartN = 1'b0;
    repeat (20) tick;
    reset = 1'b1;
    conversionStartN = 1'b1;
    repeat (3) tick;
    chk(busy === 1'b0 && dataOeN === 16'hFFFF, "reset state");
    reset = 1'b0;
    repeat (10) tick;
    chk(busy === 1'b0, "restart after reset");
    repeat (90) tick;
    chk(busy === 1'b0, "aborted run went on");
    convert(16'h0F0F);
    repeat (3) tick;
    chk(dataOut === 16'h0F0F, "word after reset");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    repeat (3) tick;
    t_parallel;
    t_master;
    t_slave;
    t_error;
    t_reset;
    test_done;
  end
  // Whole run needs about 20 us
  initial begin
    #400000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    test_done;
  end
endmodule
bind adc_result_output_port adc_result_output_port_properties
  adc_result_output_port_properties_i (.sys_clk(sys_clk), .reset(reset),
  .conversionStartN(conversionStartN), .converterSelectN(converterSelectN),
  .readEnableN(readEnableN), .portFormatSelect(portFormatSelect),
  .frameMarkerPolarity(frameMarkerPolarity), .dataOut(dataOut),
  .dataOeN(dataOeN), .busy(busy));
